// ---- src/usi_serial_shifter.sv ----
// serial shift unit: 8-bit shifter, 4-bit edge counter, three- and two-wire pins
`timescale 1ns/1ps
module usi_serial_shifter (
    input  wire logic       clock_in,
    input  wire logic       rst_b_in,
    input  wire logic       ce_in,
    input  wire logic       reg_sel_in,
    input  wire logic       reg_wr_in,
    input  wire logic [1:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       timer_match_in,
    output logic      [7:0] reg_rdata_out,
    output logic            wake_out,
    usi_link_if.device      link
);

    // ======================================================================
    // state
    typedef struct packed {
        logic [7:0] shift_data_register;
        logic [3:0] cnt;
        logic       counter_overflow_flag;
        logic [6:0] ctl;
        logic [2:0] port;
        logic       latch_open;
        logic       latch_q;
        logic       ck_s1;
        logic       ck_s2;
        logic       ck_s3;
        logic       dt_s1;
        logic       dt_s2;
        logic [7:0] rdata;
        logic       wake;
        logic       clk_out;
        logic       clk_oe;
        logic       dat_out;
        logic       dat_oe;
        logic       two;
    } dev_state_type;

    dev_state_type st_ff;
    dev_state_type nxt_st;

    logic       wr_data;
    logic       wr_status;
    logic       wr_control;
    logic       wr_port;
    logic       rd_any;
    logic       ext_sel;
    logic       two_wire;
    logic       edge_mode1;
    logic       rise;
    logic       fall;
    logic       sample_ev;
    logic       change_ev;
    logic       sw_strobe;
    logic       shift_ev;
    logic       count_ev;
    logic       hold_clk;
    logic       latch_on;
    logic [3:0] cnt_inc;

    // ======================================================================
    // next state
    always_comb begin
        nxt_st     = st_ff;
        wr_data    = reg_sel_in & reg_wr_in & (reg_addr_in == usi_pkg::REG_DATA);
        wr_status  = reg_sel_in & reg_wr_in & (reg_addr_in == usi_pkg::REG_STATUS);
        wr_control = reg_sel_in & reg_wr_in & (reg_addr_in == usi_pkg::REG_CONTROL);
        wr_port    = reg_sel_in & reg_wr_in & (reg_addr_in == usi_pkg::REG_PORT);
        rd_any     = reg_sel_in & ~reg_wr_in;

        // two-flop synchronisers, third flop only for edge history
        nxt_st.ck_s1 = link.scl;
        nxt_st.ck_s2 = st_ff.ck_s1;
        nxt_st.ck_s3 = st_ff.ck_s2;
        nxt_st.dt_s1 = link.dev_din;
        nxt_st.dt_s2 = st_ff.dt_s1;
        rise         = st_ff.ck_s2 & ~st_ff.ck_s3;
        fall         = ~st_ff.ck_s2 & st_ff.ck_s3;

        ext_sel    = st_ff.ctl[usi_pkg::CTL_EXT];
        two_wire   = st_ff.ctl[usi_pkg::CTL_WM1];
        // two-wire forces the positive-edge shift arrangement
        edge_mode1 = st_ff.ctl[usi_pkg::CTL_EDGE] & ~two_wire;
        sample_ev  = ext_sel & (edge_mode1 ? fall : rise);
        change_ev  = ext_sel & (edge_mode1 ? rise : fall);

        sw_strobe  = wr_control & reg_wdata_in[usi_pkg::CTL_STROBE];
        // internal source: software strobe, or timer match while CTL_STROBE is clear; at most one shift per cycle
        shift_ev   = ext_sel ? sample_ev
                   : (sw_strobe | (~st_ff.ctl[usi_pkg::CTL_STROBE] & timer_match_in));
        count_ev   = ~ext_sel ? shift_ev
                   : (st_ff.ctl[usi_pkg::CTL_STROBE]
                      ? (wr_control & reg_wdata_in[usi_pkg::CTL_TOGGLE])
                      : (rise | fall));

        // ==================================================================
        // control and port registers
        if (wr_control) begin
            nxt_st.ctl = reg_wdata_in[6:0] & ~7'h03;
            nxt_st.ctl[usi_pkg::CTL_STROBE] = reg_wdata_in[usi_pkg::CTL_STROBE];
        end
        if (wr_port) begin
            nxt_st.port = reg_wdata_in[2:0];
        end
        if (wr_control && reg_wdata_in[usi_pkg::CTL_TOGGLE]) begin
            nxt_st.port[usi_pkg::PORT_CLK_VAL] = ~st_ff.port[usi_pkg::PORT_CLK_VAL];
        end

        // ==================================================================
        // shift register, cpu write wins over a shift in the same cycle
        if (wr_data) begin
            nxt_st.shift_data_register = reg_wdata_in;
        end else if (shift_ev) begin
            nxt_st.shift_data_register = {st_ff.shift_data_register[6:0], st_ff.dt_s2};
        end

        // ==================================================================
        // counter and overflow flag; a wrap outranks a clearing write
        cnt_inc = st_ff.cnt + 4'h1;
        if (wr_status) begin
            nxt_st.cnt = reg_wdata_in[3:0];
            if (reg_wdata_in[usi_pkg::STS_FLAG]) begin
                nxt_st.counter_overflow_flag = 1'b0;
            end
        end else if (count_ev) begin
            nxt_st.cnt = cnt_inc;
        end
        if (count_ev && st_ff.cnt == usi_pkg::CNT_MAX) begin
            nxt_st.counter_overflow_flag = 1'b1;
        end
        nxt_st.wake = nxt_st.counter_overflow_flag & nxt_st.ctl[usi_pkg::CTL_OVF_IE];

        // ==================================================================
        // output latch: opens on the change edge, closes on the sample edge
        if (sample_ev) begin
            nxt_st.latch_open = 1'b0;
        end else if (change_ev) begin
            nxt_st.latch_open = 1'b1;
        end
        latch_on = ~ext_sel | change_ev | (st_ff.latch_open & ~sample_ev);
        if (latch_on) begin
            nxt_st.latch_q = nxt_st.shift_data_register[7];
        end

        // ==================================================================
        // pins; two-wire lines are open drain
        hold_clk   = nxt_st.ctl[usi_pkg::CTL_WM1] & nxt_st.counter_overflow_flag;
        nxt_st.two = nxt_st.ctl[usi_pkg::CTL_WM1];
        if (nxt_st.ctl[usi_pkg::CTL_WM1]) begin
            nxt_st.clk_out = 1'b0;
            nxt_st.clk_oe  = hold_clk | (nxt_st.port[usi_pkg::PORT_CLK_DIR]
                                         & ~nxt_st.port[usi_pkg::PORT_CLK_VAL]);
            nxt_st.dat_out = 1'b0;
            nxt_st.dat_oe  = nxt_st.port[usi_pkg::PORT_DAT_DIR] & ~nxt_st.latch_q;
        end else begin
            // three-wire push-pull, no select input at all
            nxt_st.clk_out = nxt_st.port[usi_pkg::PORT_CLK_VAL];
            nxt_st.clk_oe  = nxt_st.port[usi_pkg::PORT_CLK_DIR];
            nxt_st.dat_out = nxt_st.latch_q;
            nxt_st.dat_oe  = nxt_st.port[usi_pkg::PORT_DAT_DIR];
        end

        // ==================================================================
        // read data, one cycle after the select
        if (rd_any) begin
            case (reg_addr_in)
                usi_pkg::REG_DATA: begin
                    nxt_st.rdata = st_ff.shift_data_register;
                end
                usi_pkg::REG_STATUS: begin
                    nxt_st.rdata = 8'h00;
                    nxt_st.rdata[usi_pkg::STS_FLAG] = st_ff.counter_overflow_flag;
                    nxt_st.rdata[3:0] = st_ff.cnt;
                end
                usi_pkg::REG_CONTROL: begin
                    nxt_st.rdata = {1'b0, st_ff.ctl & ~7'h03};
                end
                default: begin
                    nxt_st.rdata = {5'h00, st_ff.port};
                end
            endcase
        end
    end

    // ======================================================================
    // registers
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            st_ff       <= '0;
            // clock history starts at the idle line level, so no false edge follows reset
            st_ff.ck_s1 <= 1'b1;
            st_ff.ck_s2 <= 1'b1;
            st_ff.ck_s3 <= 1'b1;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    // ======================================================================
    // outputs
    assign reg_rdata_out     = st_ff.rdata;
    assign wake_out          = st_ff.wake;
    assign link.dev_clk_out  = st_ff.clk_out;
    assign link.dev_clk_oe   = st_ff.clk_oe;
    assign link.dev_dat_out  = st_ff.dat_out;
    assign link.dev_dat_oe   = st_ff.dat_oe;
    assign link.dev_two_wire = st_ff.two;

endmodule

// ---- src/usi_pkg.sv ----
// shared constants and types for the serial shifter and its link partner
package usi_pkg;

    // ======================================================================
    // widths
    localparam int          DATA_W        = 8;
    localparam int          CNT_W         = 4;
    localparam logic [3:0]  CNT_MAX       = 4'hF;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;

    // ======================================================================
    // shifter register indices on its cpu port
    localparam logic [1:0]  REG_DATA      = 2'h0;
    localparam logic [1:0]  REG_STATUS    = 2'h1;
    localparam logic [1:0]  REG_CONTROL   = 2'h2;
    localparam logic [1:0]  REG_PORT      = 2'h3;

    // control register fields
    localparam int          CTL_TOGGLE    = 0;
    localparam int          CTL_STROBE    = 1;
    localparam int          CTL_EDGE      = 2;
    localparam int          CTL_EXT       = 3;
    localparam int          CTL_WM0       = 4;
    localparam int          CTL_WM1       = 5;
    localparam int          CTL_OVF_IE    = 6;
    localparam logic [6:0]  CTL_RESET     = 7'h00;

    // status register fields
    localparam int          STS_FLAG      = 6;

    // port register fields
    localparam int          PORT_CLK_VAL  = 0;
    localparam int          PORT_CLK_DIR  = 1;
    localparam int          PORT_DAT_DIR  = 2;
    localparam logic [2:0]  PORT_RESET    = 3'h0;

    // ======================================================================
    // partner apb map
    localparam logic [7:0]  HOST_CTRL     = 8'h00;
    localparam logic [7:0]  HOST_TX       = 8'h04;
    localparam logic [7:0]  HOST_RX       = 8'h08;
    localparam logic [7:0]  HOST_STAT     = 8'h0C;
    localparam int          HC_START      = 0;
    localparam int          HC_MODE1      = 1;
    localparam int          HC_TWO        = 2;
    localparam int          HC_DRIVE      = 3;
    localparam int          HS_BUSY       = 0;
    localparam int          HS_DONE       = 1;

    // ======================================================================
    // timing
    localparam int          CLK_MHZ       = 25;
    localparam int          LINK_HALF_NS  = 320;
    localparam int          LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        H_IDLE  = 2'b00,
        H_SETUP = 2'b01,
        H_HIGH  = 2'b10,
        H_LOW   = 2'b11
    } host_state_type;

endpackage

// ---- src/usi_link_if.sv ----
// link between the serial shifter and its remote partner, with wired line levels
`timescale 1ns/1ps
interface usi_link_if;
    logic dev_clk_out;
    logic dev_clk_oe;
    logic dev_dat_out;
    logic dev_dat_oe;
    logic dev_two_wire;
    logic host_clk_out;
    logic host_clk_oe;
    logic host_dat_out;
    logic host_dat_oe;
    logic scl;
    logic sda;
    logic dev_din;
    logic host_din;

    // pulled-up lines, a driver low wins
    assign scl      = (dev_clk_oe ? dev_clk_out : 1'b1) & (host_clk_oe ? host_clk_out : 1'b1);
    assign sda      = (dev_dat_oe ? dev_dat_out : 1'b1) & (host_dat_oe ? host_dat_out : 1'b1);
    assign dev_din  = dev_two_wire ? sda : (host_dat_oe ? host_dat_out : 1'b1);
    assign host_din = dev_two_wire ? sda : (dev_dat_oe ? dev_dat_out : 1'b1);

    modport device (
        output dev_clk_out,
        output dev_clk_oe,
        output dev_dat_out,
        output dev_dat_oe,
        output dev_two_wire,
        input  scl,
        input  dev_din
    );
    modport partner (
        output host_clk_out,
        output host_clk_oe,
        output host_dat_out,
        output host_dat_oe,
        input  scl,
        input  host_din
    );
endinterface

// ---- src/usi_link_partner.sv ----
// remote master for the serial shifter, driven through apb registers
`timescale 1ns/1ps
module usi_link_partner #(
    parameter int HALF_CYC = usi_pkg::LINK_HALF_CYC
) (
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    input  wire logic        ce_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    usi_link_if.partner      link
);

    localparam logic [7:0] HALF_LOAD = 8'(HALF_CYC - 1);

    // ======================================================================
    // state
    typedef struct packed {
        usi_pkg::host_state_type state;
        logic [7:0]  half;
        logic [3:0]  bits;
        logic [7:0]  sr;
        logic [7:0]  tx;
        logic [7:0]  rx;
        logic        mode1;
        logic        two;
        logic        drive;
        logic        done;
        logic        clk_lvl;
        logic        dat;
        logic        ck_s1;
        logic        ck_s2;
        logic        dt_s1;
        logic        dt_s2;
        logic [31:0] rdata;
        logic        ready;
        logic        clk_out;
        logic        clk_oe;
        logic        dat_out;
        logic        dat_oe;
    } host_state_type_s_type;

    host_state_type_s_type st_ff;
    host_state_type_s_type nxt_st;

    logic take;
    logic rise_ev;
    logic fall_ev;

    always_comb begin
        nxt_st       = st_ff;
        rise_ev      = 1'b0;
        fall_ev      = 1'b0;
        nxt_st.ck_s1 = link.scl;
        nxt_st.ck_s2 = st_ff.ck_s1;
        nxt_st.dt_s1 = link.host_din;
        nxt_st.dt_s2 = st_ff.dt_s1;

        // ==================================================================
        // apb: ready one cycle into the access phase
        take         = psel & penable & st_ff.ready;
        nxt_st.ready = psel & penable & ~st_ff.ready;
        if (psel && penable && !st_ff.ready && !pwrite) begin
            case (paddr)
                usi_pkg::HOST_CTRL: nxt_st.rdata = {28'h0, st_ff.drive, st_ff.two, st_ff.mode1, 1'b0};
                usi_pkg::HOST_TX:   nxt_st.rdata = {24'h0, st_ff.tx};
                usi_pkg::HOST_RX:   nxt_st.rdata = {24'h0, st_ff.rx};
                usi_pkg::HOST_STAT: nxt_st.rdata = {30'h0, st_ff.done, st_ff.state != usi_pkg::H_IDLE};
                default:            nxt_st.rdata = 32'h0;
            endcase
        end
        if (take && pwrite) begin
            if (paddr == usi_pkg::HOST_TX) begin
                nxt_st.tx = pwdata[7:0];
            end
            if (paddr == usi_pkg::HOST_CTRL && st_ff.state == usi_pkg::H_IDLE) begin
                nxt_st.mode1 = pwdata[usi_pkg::HC_MODE1];
                nxt_st.two   = pwdata[usi_pkg::HC_TWO];
                nxt_st.drive = pwdata[usi_pkg::HC_DRIVE];
            end
            if (paddr == usi_pkg::HOST_STAT && pwdata[usi_pkg::HS_DONE]) begin
                nxt_st.done = 1'b0;
            end
        end

        // ==================================================================
        // transfer sequencer
        case (st_ff.state)
            usi_pkg::H_IDLE: begin
                if (take && pwrite && paddr == usi_pkg::HOST_CTRL && pwdata[usi_pkg::HC_START]) begin
                    // data stands a half cycle before the first rising edge
                    nxt_st.sr      = st_ff.tx;
                    nxt_st.dat     = st_ff.tx[7];
                    nxt_st.clk_lvl = 1'b0;
                    nxt_st.bits    = 4'h0;
                    nxt_st.half    = HALF_LOAD;
                    nxt_st.state   = usi_pkg::H_SETUP;
                end
            end
            usi_pkg::H_SETUP: begin
                if (st_ff.half == 8'h00) begin
                    rise_ev = 1'b1;
                end else begin
                    nxt_st.half = st_ff.half - 8'h01;
                end
            end
            usi_pkg::H_HIGH: begin
                if (st_ff.two && !st_ff.ck_s2) begin
                    nxt_st.half = HALF_LOAD;
                end else if (st_ff.half == 8'h00) begin
                    fall_ev        = 1'b1;
                    nxt_st.clk_lvl = 1'b0;
                    nxt_st.half    = HALF_LOAD;
                    nxt_st.state   = usi_pkg::H_LOW;
                end else begin
                    nxt_st.half = st_ff.half - 8'h01;
                end
            end
            usi_pkg::H_LOW: begin
                if (st_ff.half != 8'h00) begin
                    nxt_st.half = st_ff.half - 8'h01;
                end else if (st_ff.bits == usi_pkg::BYTE_BITS) begin
                    nxt_st.rx    = st_ff.sr;
                    nxt_st.done  = 1'b1;
                    nxt_st.state = usi_pkg::H_IDLE;
                end else begin
                    rise_ev = 1'b1;
                end
            end
            default: begin
                nxt_st.state = usi_pkg::H_IDLE;
            end
        endcase
        if (rise_ev) begin
            nxt_st.clk_lvl = 1'b1;
            nxt_st.half    = HALF_LOAD;
            nxt_st.state   = usi_pkg::H_HIGH;
        end
        if ((rise_ev && !st_ff.mode1) || (fall_ev && st_ff.mode1)) begin
            nxt_st.sr   = {st_ff.sr[6:0], st_ff.dt_s2};
            nxt_st.bits = st_ff.bits + 4'h1;
        end else if (rise_ev || fall_ev) begin
            nxt_st.dat = st_ff.sr[7];
        end

        // ==================================================================
        // pins
        if (nxt_st.two) begin
            nxt_st.clk_out = 1'b0;
            nxt_st.clk_oe  = ~nxt_st.clk_lvl;
            nxt_st.dat_out = 1'b0;
            nxt_st.dat_oe  = nxt_st.drive & ~nxt_st.dat;
        end else begin
            nxt_st.clk_out = nxt_st.clk_lvl;
            nxt_st.clk_oe  = nxt_st.drive;
            nxt_st.dat_out = nxt_st.dat;
            nxt_st.dat_oe  = nxt_st.drive;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    assign prdata            = st_ff.rdata;
    assign pready            = st_ff.ready;
    assign pslverr           = 1'b0;
    assign link.host_clk_out = st_ff.clk_out;
    assign link.host_clk_oe  = st_ff.clk_oe;
    assign link.host_dat_out = st_ff.dat_out;
    assign link.host_dat_oe  = st_ff.dat_oe;

endmodule

// ---- tb/usi_asserts.sv ----
// concurrent checks on the link between the two serial ends
`timescale 1ns/1ps
module usi_asserts (
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic host_clk_out,
    input wire logic host_clk_oe,
    input wire logic host_dat_out,
    input wire logic dev_dat_out,
    input wire logic dev_clk_oe,
    input wire logic scl
);
    // level the partner asks for, push-pull or open drain
    logic host_lvl;
    assign host_lvl = host_clk_oe ? host_clk_out : 1'b1;

    // ======================================================================
    // clock phases and data timing
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_high; host_lvl[*5]; endsequence
    sequence s_low; !host_lvl[*5]; endsequence
    property p_high_min; $rose(host_lvl) |=> s_high; endproperty
    property p_low_min; $fell(host_lvl) |=> s_low; endproperty
    property p_high_max; $rose(scl) && host_lvl |-> ##[4:12] !host_lvl; endproperty
    property p_stretch; $fell(host_lvl) |-> $past(scl) && $past(scl, 4); endproperty
    property p_setup; $rose(host_clk_out) |-> $past(host_dat_out, 3) == $past(host_dat_out); endproperty
    property p_hold; host_clk_out && $past(host_clk_out) |-> $stable(host_dat_out); endproperty
    property p_sync; $changed(scl) && !dev_clk_oe |=> $stable(dev_dat_out)[*2]; endproperty
    property p_dev_edge; $changed(host_clk_out) |-> $past(dev_dat_out, 2) == dev_dat_out; endproperty
    a_high_min: assert property (p_high_min) else $error("high phase short");
    a_low_min: assert property (p_low_min) else $error("low phase short");
    a_high_max: assert property (p_high_max) else $error("high phase long");
    a_stretch: assert property (p_stretch) else $error("clock fell while line low");
    a_setup: assert property (p_setup) else $error("partner data setup");
    a_hold: assert property (p_hold) else $error("partner data moved while high");
    a_sync: assert property (p_sync) else $error("device data moved too soon");
    a_dev_edge: assert property (p_dev_edge) else $error("device data moved at edge");
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench: shifter and link partner joined back to back
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("MISMATCH %0t %s", $time, m); end end
module tb_top;
    logic        clock_in;
    logic        rst_b_in;
    logic        ce_in;
    logic        reg_sel_in;
    logic        reg_wr_in;
    logic [1:0]  reg_addr_in;
    logic [7:0]  reg_wdata_in;
    logic        timer_match_in;
    logic [7:0]  reg_rdata_out;
    logic        wake_out;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic [31:0] r32;
    logic [7:0]  r8;
    int          err_count;
    int          num_checks;
    int          n;
    // device control, partner control, device port, device byte, partner byte
    logic [7:0]  rows [3][5] = '{'{8'h58, 8'h09, 8'h04, 8'h3C, 8'hA5},
                                 '{8'h1C, 8'h0B, 8'h04, 8'hC3, 8'h5A},
                                 '{8'h28, 8'h0D, 8'h00, 8'hFF, 8'h96}};

    usi_link_if usi_link_if_inst ();
    usi_serial_shifter usi_serial_shifter_inst (.clock_in, .rst_b_in, .ce_in, .reg_sel_in, .reg_wr_in, .reg_addr_in,
        .reg_wdata_in, .timer_match_in, .reg_rdata_out, .wake_out, .link(usi_link_if_inst));
    usi_link_partner usi_link_partner_inst (.clock_in, .rst_b_in, .ce_in, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr(), .link(usi_link_if_inst));
    usi_asserts usi_asserts_inst (.clock_in, .rst_b_in, .host_clk_out(usi_link_if_inst.host_clk_out),
        .host_clk_oe(usi_link_if_inst.host_clk_oe),
        .host_dat_out(usi_link_if_inst.host_dat_out), .dev_dat_out(usi_link_if_inst.dev_dat_out),
        .dev_clk_oe(usi_link_if_inst.dev_clk_oe), .scl(usi_link_if_inst.scl));

    // ======================================================================
    // bus tasks
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d, input logic t,
                       output logic [7:0] r);
        @(posedge clock_in);
        reg_sel_in <= 1'b1;
        reg_wr_in <= w;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        timer_match_in <= t;
        @(posedge clock_in);
        reg_sel_in <= 1'b0;
        timer_match_in <= 1'b0;
        #1 r = reg_rdata_out;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clock_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_in);
        penable <= 1'b1;
        do @(posedge clock_in); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ======================================================================
    // clock, watchdog, tests
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end

    initial begin
        repeat (20000) @(posedge clock_in);
        err_count++;
        $display("MISMATCH %0t watchdog", $time);
        stop_test;
    end

    initial begin
        {rst_b_in, reg_sel_in, reg_wr_in, reg_addr_in, reg_wdata_in, timer_match_in} = '0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ce_in = 1'b1;
        repeat (5) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        `CHK(wake_out, 1'b0, "wake after reset")
        apb(1'b0, 8'h10, 32'h0, r32);
        `CHK(r32, 32'h0, "unmapped read")
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 2'h3, rows[i][2], 1'b0, r8);
            acc(1'b1, 2'h2, rows[i][0], 1'b0, r8);
            acc(1'b1, 2'h0, rows[i][3], 1'b0, r8);
            apb(1'b1, 8'h04, {24'h0, rows[i][4]}, r32);
            apb(1'b1, 8'h00, {24'h0, rows[i][1]}, r32);
            n = 0;
            while (usi_link_if_inst.scl !== 1'b0 && n < 40) begin
                @(posedge clock_in);
                n++;
            end
            // two-wire: the flag left from the last row holds the clock past the first release
            repeat (rows[i][0][5] ? 20 : 4) @(posedge clock_in);
            acc(1'b1, 2'h1, 8'h40, 1'b0, r8);
            r32 = '0;
            while (r32[usi_pkg::HS_DONE] !== 1'b1) apb(1'b0, 8'h0C, 32'h0, r32);
            apb(1'b0, 8'h08, 32'h0, r32);
            `CHK(r32[7:0], rows[i][0][5] ? rows[i][4] : rows[i][3], "partner byte")
            acc(1'b0, 2'h0, 8'h00, 1'b0, r8);
            `CHK(r8, rows[i][4], "device byte")
            acc(1'b0, 2'h1, 8'h00, 1'b0, r8);
            `CHK(r8[6], 1'b1, "overflow flag")
            `CHK(wake_out, rows[i][0][6], "wake")
            `CHK(usi_link_if_inst.dev_clk_oe, rows[i][0][5], "clock hold")
            apb(1'b1, 8'h0C, 32'h2, r32);
            $display("row %0d done", i);
        end
        acc(1'b1, 2'h2, 8'h10, 1'b0, r8);
        acc(1'b1, 2'h1, 8'h4E, 1'b0, r8);
        acc(1'b0, 2'h1, 8'h00, 1'b0, r8);
        `CHK(r8, 8'h0E, "counter load")
        repeat (2) acc(1'b0, 2'h0, 8'h00, 1'b1, r8);
        acc(1'b0, 2'h1, 8'h00, 1'b0, r8);
        `CHK(r8, 8'h40, "wrap")
        acc(1'b1, 2'h0, 8'hA5, 1'b1, r8);
        acc(1'b0, 2'h0, 8'h00, 1'b0, r8);
        `CHK(r8, 8'hA5, "write beats shift")
        $display("timer test done");
        acc(1'b1, 2'h1, 8'h40, 1'b0, r8);
        for (int k = 0; k < 8; k++) begin
            acc(1'b1, 2'h2, 8'h11, 1'b0, r8);
            `CHK(usi_link_if_inst.dev_clk_out, 1'b1, "clock toggle")
            acc(1'b1, 2'h2, 8'h13, 1'b0, r8);
        end
        acc(1'b0, 2'h1, 8'h00, 1'b0, r8);
        `CHK(r8, 8'h08, "strobe count")
        acc(1'b1, 2'h1, 8'h40, 1'b0, r8);
        repeat (3) acc(1'b1, 2'h2, 8'h1B, 1'b0, r8);
        acc(1'b0, 2'h1, 8'h00, 1'b0, r8);
        `CHK(r8, 8'h03, "toggle count")
        $display("strobe test done");
        @(posedge clock_in);
        rst_b_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        rst_b_in <= 1'b1;
        acc(1'b0, 2'h1, 8'h00, 1'b0, r8);
        `CHK({r8, wake_out, usi_link_if_inst.dev_clk_oe, usi_link_if_inst.dev_dat_oe}, 11'h000, "mid-run reset")
        $display("reset test done");
        stop_test;
    end
endmodule
